/* rtl/sic_pkg.sv */
package sic_pkg;

  // special function register byte addresses
  localparam logic [7:0] ADDR_IE1 = 8'h00;
  localparam logic [7:0] ADDR_IE2 = 8'h01;
  localparam logic [7:0] ADDR_IFG1 = 8'h02;
  localparam logic [7:0] ADDR_IFG2 = 8'h03;

  // first enable register fields
  localparam int IE_WDT = 0;
  localparam int IE_OSC = 1;
  localparam int IE_PIN = 4;
  localparam int IE_ACCV = 5;
  localparam logic [7:0] IE1_MASK = 8'h33;
  localparam logic [7:0] IE1_PUC_VAL = 8'h00;

  // first flag register fields
  localparam int IFG_WDT = 0;
  localparam int IFG_OSC = 1;
  localparam int IFG_POR = 2;
  localparam int IFG_RST = 3;
  localparam int IFG_PIN = 4;
  localparam logic [7:0] IFG1_MASK = 8'h1F;
  localparam logic [7:0] IFG1_POR_VAL = 8'h06;

  // vector words and their priorities
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_NMI = 16'hFFFC;
  localparam logic [15:0] VEC_COMP = 16'hFFF6;
  localparam logic [15:0] VEC_WDT = 16'hFFF4;
  localparam logic [15:0] VEC_TMR_ZERO = 16'hFFF2;
  localparam logic [15:0] VEC_TMR_OTHER = 16'hFFF0;
  localparam logic [15:0] VEC_PORT_TWO = 16'hFFE6;
  localparam logic [15:0] VEC_PORT_ONE = 16'hFFE4;
  localparam logic [15:0] VEC_NONE = 16'h0000;
  localparam logic [4:0] PRI_RESET = 5'h1F;
  localparam logic [4:0] PRI_NMI = 5'h1E;
  localparam logic [4:0] PRI_COMP = 5'h1B;
  localparam logic [4:0] PRI_WDT = 5'h1A;
  localparam logic [4:0] PRI_TMR_ZERO = 5'h19;
  localparam logic [4:0] PRI_TMR_OTHER = 5'h18;
  localparam logic [4:0] PRI_PORT_TWO = 5'h13;
  localparam logic [4:0] PRI_PORT_ONE = 5'h12;
  localparam logic [4:0] PRI_NONE = 5'h00;

  // special word values
  localparam logic [15:0] BLANK_WORD = 16'hFFFF;
  localparam logic [15:0] KEY_LOADER_OFF = 16'hAA55;
  localparam logic [15:0] KEY_ERASE_GUARD = 16'h0000;

  // fetch map; ram and code limits vary between parts
  localparam logic [15:0] PERIPH_TOP = 16'h01FF;
  localparam logic [15:0] RAM_BASE = 16'h0200;
  localparam logic [15:0] RAM_TOP = 16'h02FF;
  localparam logic [15:0] BOOT_BASE = 16'h0C00;
  localparam logic [15:0] INFO_TOP = 16'h10FF;
  localparam logic [15:0] CODE_BASE = 16'hE000;

  typedef enum logic [2:0] {
    SIC_ACTIVE = 3'h0,
    SIC_SLEEP0 = 3'h1,
    SIC_SLEEP1 = 3'h2,
    SIC_SLEEP2 = 3'h3,
    SIC_SLEEP3 = 3'h4,
    SIC_SLEEP4 = 3'h5
  } sic_mode_t;

endpackage : sic_pkg

/* rtl/sic_ctrl.sv */
// How it works
// - active state plus five sleep levels; interrupts wake, return restores level.
// - active state keeps auxiliary, main and peripheral clocks running.
// - sleep level 0 halts cpu, stops main clock only.
// - level 1 as level 0, dc generator off unless used when active.
// - level 2 stops main and peripheral clocks, dc generator stays on.
// - level 3 leaves only auxiliary clock; dc generator off.
// - level 4 stops all clocks, dc generator and crystal oscillator.
// - vector words sit at the top; each holds a 16-bit handler address.
// - blank reset vector sends the device to sleep level 4 after reset.
// - power-up, pin, watchdog, key violation, bad fetch cause reset, priority 31.
// - fetch from peripheral area or unused range forces reset.
// - pin event, oscillator fault, access violation share vector, priority 30.
// - those sources are gated by own enable only, never global enable.
// - fixed maskable vectors and priorities for comparator, watchdog, timer, ports.
// - shared vectors take flags from the peripheral modules themselves.
// - loader key 0xAA55 disables loader; 0x0 blocks erase on bad password.
// - lowest vector words raise no interrupt.
// - unassigned register bits are not built.
// - plain reset values load on power-up clear, bracketed only on power-on.
// - enable register bits 0,1,4,5; read/write; cleared by power-up clear.
// - watchdog enable acts only in interval timer mode.
// - power-on, pin reset and oscillator fault flags set by their events.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module sic_ctrl (
  // clock and power-on reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // reset / non-maskable pin
  input wire logic i_rst_pin_n,
  input wire logic i_pin_nmi_mode,
  // cpu side
  input wire logic i_gie,
  input wire logic i_sleep_wr,
  input wire logic [2:0] i_sleep_level,
  input wire logic i_reti,
  input wire logic i_fetch_valid,
  input wire logic [15:0] i_fetch_addr,
  input wire logic [15:0] i_reset_vector,
  input wire logic [15:0] i_loader_key,
  // peripheral events and flags
  input wire logic i_wdt_expire,
  input wire logic i_wdt_interval_mode,
  input wire logic i_key_violation,
  input wire logic i_osc_fault,
  input wire logic i_access_violation_flag,
  input wire logic i_comparator_flag,
  input wire logic i_timer_zero_flag,
  input wire logic i_timer_other_flag,
  input wire logic i_port_two_flag,
  input wire logic i_port_one_flag,
  input wire logic i_dco_used_active,
  // interrupt request to cpu
  output logic o_irq_req,
  output logic [15:0] o_irq_vector,
  output logic [4:0] o_irq_priority,
  output logic o_power_up_clear,
  // operating mode and clock gating
  output logic [2:0] o_mode,
  output logic o_cpu_halt,
  output logic o_aux_clk_en,
  output logic o_main_clk_en,
  output logic o_periph_clk_en,
  output logic o_dc_gen_en,
  output logic o_xtal_en,
  // loader key decode
  output logic o_loader_disabled,
  output logic o_erase_guard
);

  // pin synchroniser and filtered level
  logic pin_s1_ff;
  logic pin_s2_ff;
  logic pin_s3_ff;
  logic pin_lvl_ff;
  logic nxt_pin_lvl;

  // control state
  logic puc_ff;
  logic [7:0] ie_ff;
  logic [7:0] ifg_ff;
  logic [7:0] nxt_ie;
  logic [7:0] nxt_ifg;
  sic_pkg::sic_mode_t mode_ff;
  sic_pkg::sic_mode_t saved_ff;
  sic_pkg::sic_mode_t nxt_mode;
  sic_pkg::sic_mode_t nxt_saved;

  // registered outputs
  logic [7:0] rdata_ff;
  logic irq_req_ff;
  logic [15:0] irq_vec_ff;
  logic [4:0] irq_pri_ff;
  logic halt_ff;
  logic aux_ff;
  logic main_ff;
  logic periph_ff;
  logic dc_ff;
  logic xtal_ff;
  logic loader_off_ff;
  logic erase_guard_ff;

  // pin decode: a change counts once stages two and three agree
  wire pin_stable = (pin_s2_ff == pin_s3_ff);
  assign nxt_pin_lvl = pin_stable ? pin_s3_ff : pin_lvl_ff;
  wire pin_fall = pin_stable & ~pin_s3_ff & pin_lvl_ff;
  wire pin_rst = ~pin_lvl_ff & ~i_pin_nmi_mode;
  wire pin_nmi_evt = pin_fall & i_pin_nmi_mode;

  // fetch outside ram, boot/info and code space
  // limits fit the largest part; smaller parts leave more of the map unused
  wire fetch_periph = (i_fetch_addr <= sic_pkg::PERIPH_TOP);
  wire fetch_ram = (i_fetch_addr >= sic_pkg::RAM_BASE) &
                   (i_fetch_addr <= sic_pkg::RAM_TOP);
  wire fetch_boot = (i_fetch_addr >= sic_pkg::BOOT_BASE) &
                    (i_fetch_addr <= sic_pkg::INFO_TOP);
  wire fetch_code = (i_fetch_addr >= sic_pkg::CODE_BASE);
  wire fetch_bad = i_fetch_valid &
                   (fetch_periph | ~(fetch_ram | fetch_boot | fetch_code));

  // reset-mode watchdog expiry resets; interval expiry only flags
  wire wdt_rst = i_wdt_expire & ~i_wdt_interval_mode;
  wire puc_src = pin_rst | wdt_rst | i_key_violation | fetch_bad;

  // register decode
  wire wr_ie = i_reg_wr & (i_reg_addr == sic_pkg::ADDR_IE1);
  wire wr_ifg = i_reg_wr & (i_reg_addr == sic_pkg::ADDR_IFG1);
  wire [7:0] rd_mux =
    (i_reg_addr == sic_pkg::ADDR_IE1) ? (ie_ff & sic_pkg::IE1_MASK) :
    (i_reg_addr == sic_pkg::ADDR_IFG1) ? (ifg_ff & sic_pkg::IFG1_MASK) :
    8'h00;

  // pending sources
  wire nmi_pend = (ifg_ff[sic_pkg::IFG_PIN] & ie_ff[sic_pkg::IE_PIN]) |
                  (ifg_ff[sic_pkg::IFG_OSC] & ie_ff[sic_pkg::IE_OSC]) |
                  (i_access_violation_flag & ie_ff[sic_pkg::IE_ACCV]);
  wire wdt_pend = ifg_ff[sic_pkg::IFG_WDT] & ie_ff[sic_pkg::IE_WDT] &
                  i_wdt_interval_mode & i_gie;
  // maskable sources, highest priority in the top bit; their flags live in
  // the peripherals, so a shared vector needs software to find the source
  localparam int NUM_MASKABLE = 5;
  localparam int SRC_COMP = 4;
  localparam int SRC_TMR_ZERO = 3;
  localparam int SRC_TMR_OTHER = 2;
  localparam int SRC_PORT_TWO = 1;
  localparam int SRC_PORT_ONE = 0;
  wire [NUM_MASKABLE-1:0] mask_flags = {i_comparator_flag, i_timer_zero_flag,
    i_timer_other_flag, i_port_two_flag, i_port_one_flag};
  logic [NUM_MASKABLE-1:0] mask_pend;
  for (genvar s = 0; s < NUM_MASKABLE; s++) begin : g_mask_src
    assign mask_pend[s] = mask_flags[s] & i_gie;
  end
  wire comp_pend = mask_pend[SRC_COMP];
  wire tmr0_pend = mask_pend[SRC_TMR_ZERO];
  wire tmr1_pend = mask_pend[SRC_TMR_OTHER];
  wire port2_pend = mask_pend[SRC_PORT_TWO];
  wire port1_pend = mask_pend[SRC_PORT_ONE];
  // words below the port vectors have no source at all
  wire any_pend = ~puc_ff & (nmi_pend | wdt_pend | comp_pend | tmr0_pend |
                  tmr1_pend | port2_pend | port1_pend);

  // fixed-priority selection, highest number first
  wire [15:0] sel_vec =
    nmi_pend ? sic_pkg::VEC_NMI :
    comp_pend ? sic_pkg::VEC_COMP :
    wdt_pend ? sic_pkg::VEC_WDT :
    tmr0_pend ? sic_pkg::VEC_TMR_ZERO :
    tmr1_pend ? sic_pkg::VEC_TMR_OTHER :
    port2_pend ? sic_pkg::VEC_PORT_TWO :
    port1_pend ? sic_pkg::VEC_PORT_ONE :
    sic_pkg::VEC_NONE;
  wire [4:0] sel_pri =
    nmi_pend ? sic_pkg::PRI_NMI :
    comp_pend ? sic_pkg::PRI_COMP :
    wdt_pend ? sic_pkg::PRI_WDT :
    tmr0_pend ? sic_pkg::PRI_TMR_ZERO :
    tmr1_pend ? sic_pkg::PRI_TMR_OTHER :
    port2_pend ? sic_pkg::PRI_PORT_TWO :
    port1_pend ? sic_pkg::PRI_PORT_ONE :
    sic_pkg::PRI_NONE;

  // wake needs a request the cpu would take; a masked flag leaves it asleep
  wire wake = any_pend & (mode_ff != sic_pkg::SIC_ACTIVE);
  wire level_ok = (i_sleep_level <= 3'(sic_pkg::SIC_SLEEP4));

  // clock gating decoded from the current mode
  wire is_act = (mode_ff == sic_pkg::SIC_ACTIVE);
  wire is_l0 = (mode_ff == sic_pkg::SIC_SLEEP0);
  wire is_l1 = (mode_ff == sic_pkg::SIC_SLEEP1);
  wire is_l2 = (mode_ff == sic_pkg::SIC_SLEEP2);
  wire is_l4 = (mode_ff == sic_pkg::SIC_SLEEP4);
  wire nxt_main = is_act;
  wire nxt_periph = is_act | is_l0 | is_l1;
  wire nxt_aux = ~is_l4;
  wire nxt_dc = is_act | is_l0 | (is_l1 & i_dco_used_active) | is_l2;
  wire nxt_xtal = ~is_l4;

  // mode sequencing
  // one saved slot: a wake needs a sleeping mode, so nothing nests
  always_comb begin
    nxt_mode = mode_ff;
    nxt_saved = saved_ff;
    if (puc_ff) begin
      nxt_saved = sic_pkg::SIC_ACTIVE;
      if (i_reset_vector == sic_pkg::BLANK_WORD) begin
        nxt_mode = sic_pkg::SIC_SLEEP4;
      end else begin
        nxt_mode = sic_pkg::SIC_ACTIVE;
      end
    end else if (wake) begin
      nxt_saved = mode_ff;
      nxt_mode = sic_pkg::SIC_ACTIVE;
    end else if (i_reti) begin
      nxt_mode = saved_ff;
      nxt_saved = sic_pkg::SIC_ACTIVE;
    end else if (i_sleep_wr && level_ok) begin
      nxt_mode = sic_pkg::sic_mode_t'(i_sleep_level);
    end
  end

  // enable register: write, then power-up clear
  always_comb begin
    nxt_ie = ie_ff;
    if (wr_ie) begin
      nxt_ie = i_reg_wdata & sic_pkg::IE1_MASK;
    end
    if (puc_ff) begin
      nxt_ie = sic_pkg::IE1_PUC_VAL;
    end
  end

  // flag register: hardware set wins over software clear
  always_comb begin
    nxt_ifg = ifg_ff;
    if (wr_ifg) begin
      nxt_ifg = i_reg_wdata & sic_pkg::IFG1_MASK;
    end
    if (puc_ff) begin
      nxt_ifg[sic_pkg::IFG_OSC] = 1'b1;
      nxt_ifg[sic_pkg::IFG_PIN] = 1'b0;
    end
    if (pin_rst) begin
      nxt_ifg[sic_pkg::IFG_WDT] = 1'b0;
      nxt_ifg[sic_pkg::IFG_RST] = 1'b1;
    end
    if (i_wdt_expire | i_key_violation) begin
      nxt_ifg[sic_pkg::IFG_WDT] = 1'b1;
    end
    if (i_osc_fault) begin
      nxt_ifg[sic_pkg::IFG_OSC] = 1'b1;
    end
    if (pin_nmi_evt) begin
      nxt_ifg[sic_pkg::IFG_PIN] = 1'b1;
    end
  end

  // pin synchroniser; idle level is high
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_s1_ff <= 1'b1;
      pin_s2_ff <= 1'b1;
      pin_s3_ff <= 1'b1;
      pin_lvl_ff <= 1'b1;
    end else begin
      pin_s1_ff <= i_rst_pin_n;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_lvl_ff <= nxt_pin_lvl;
    end
  end

  // power-on reset forces one power-up clear cycle after release
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      puc_ff <= 1'b1;
      mode_ff <= sic_pkg::SIC_ACTIVE;
      saved_ff <= sic_pkg::SIC_ACTIVE;
    end else begin
      puc_ff <= puc_src;
      mode_ff <= nxt_mode;
      saved_ff <= nxt_saved;
    end
  end

  // one flop per bit that has a purpose; the rest are tied low, not built
  for (genvar b = 0; b < 8; b++) begin : g_sfr_bit
    if (sic_pkg::IE1_MASK[b]) begin : g_ie_bit
      always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          ie_ff[b] <= sic_pkg::IE1_PUC_VAL[b];
        end else begin
          ie_ff[b] <= nxt_ie[b];
        end
      end
    end else begin : g_ie_none
      assign ie_ff[b] = 1'b0;
    end
    if (sic_pkg::IFG1_MASK[b]) begin : g_ifg_bit
      // power-on value here; the power-up clear is handled in nxt_ifg
      always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          ifg_ff[b] <= sic_pkg::IFG1_POR_VAL[b];
        end else begin
          ifg_ff[b] <= nxt_ifg[b];
        end
      end
    end else begin : g_ifg_none
      assign ifg_ff[b] = 1'b0;
    end
  end

  // request and read data registers
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_ff <= 8'h00;
      irq_req_ff <= 1'b0;
      irq_vec_ff <= sic_pkg::VEC_NONE;
      irq_pri_ff <= sic_pkg::PRI_NONE;
    end else begin
      rdata_ff <= i_reg_rd ? rd_mux : 8'h00;
      irq_req_ff <= any_pend;
      irq_vec_ff <= any_pend ? sel_vec : sic_pkg::VEC_NONE;
      irq_pri_ff <= any_pend ? sel_pri : sic_pkg::PRI_NONE;
    end
  end

  // clock gating and key decode registers; one cycle behind the mode and the loader key
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      halt_ff <= 1'b0;
      aux_ff <= 1'b1;
      main_ff <= 1'b1;
      periph_ff <= 1'b1;
      dc_ff <= 1'b1;
      xtal_ff <= 1'b1;
      loader_off_ff <= 1'b0;
      erase_guard_ff <= 1'b0;
    end else begin
      halt_ff <= ~is_act;
      aux_ff <= nxt_aux;
      main_ff <= nxt_main;
      periph_ff <= nxt_periph;
      dc_ff <= nxt_dc;
      xtal_ff <= nxt_xtal;
      loader_off_ff <= (i_loader_key == sic_pkg::KEY_LOADER_OFF);
      erase_guard_ff <= (i_loader_key == sic_pkg::KEY_ERASE_GUARD);
    end
  end

  assign o_reg_rdata = rdata_ff;
  assign o_irq_req = irq_req_ff;
  assign o_irq_vector = irq_vec_ff;
  assign o_irq_priority = irq_pri_ff;
  assign o_power_up_clear = puc_ff;
  assign o_mode = mode_ff;
  assign o_cpu_halt = halt_ff;
  assign o_aux_clk_en = aux_ff;
  assign o_main_clk_en = main_ff;
  assign o_periph_clk_en = periph_ff;
  assign o_dc_gen_en = dc_ff;
  assign o_xtal_en = xtal_ff;
  assign o_loader_disabled = loader_off_ff;
  assign o_erase_guard = erase_guard_ff;

endmodule : sic_ctrl

`default_nettype wire

/* verification/sic_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module sic_checker (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // causes
  input wire logic i_gie,
  input wire logic i_wdt_interval_mode,
  input wire logic i_dco_used_active,
  input wire logic i_fetch_valid,
  input wire logic [15:0] i_fetch_addr,
  input wire logic [15:0] i_reset_vector,
  input wire logic [15:0] i_loader_key,
  input wire logic i_comparator_flag,
  // effects
  input wire logic o_irq_req,
  input wire logic [15:0] o_irq_vector,
  input wire logic [4:0] o_irq_priority,
  input wire logic o_power_up_clear,
  input wire logic [2:0] o_mode,
  input wire logic o_cpu_halt,
  input wire logic o_aux_clk_en,
  input wire logic o_main_clk_en,
  input wire logic o_periph_clk_en,
  input wire logic o_dc_gen_en,
  input wire logic o_xtal_en,
  input wire logic o_loader_disabled,
  input wire logic o_erase_guard
);
  logic [5:0] gates_seen;
  assign gates_seen = {o_cpu_halt, o_aux_clk_en, o_main_clk_en,
                       o_periph_clk_en, o_dc_gen_en, o_xtal_en};

  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);

  // enables trail the mode by one cycle
  property p_gate(logic [2:0] m, logic [5:0] e);
    $past(o_mode) == m |-> gates_seen == e;
  endproperty

  chk_active_clocks: assert property (p_gate(3'h0, 6'h1F))
    else $error("active gating");
  chk_level0_gates: assert property (p_gate(3'h1, 6'h37))
    else $error("level 0 gating");
  chk_level1_gates: assert property ($past(o_mode) == 3'h2 |->
    gates_seen == {4'hD, $past(i_dco_used_active), 1'b1})
    else $error("level 1 gating");
  chk_level2_gates: assert property (p_gate(3'h3, 6'h33))
    else $error("level 2 gating");
  chk_level3_gates: assert property (p_gate(3'h4, 6'h31))
    else $error("level 3 gating");
  chk_level4_gates: assert property (p_gate(3'h5, 6'h20))
    else $error("level 4 gating");
  chk_nmi_only: assert property (o_irq_req && !$past(i_gie) |->
    o_irq_vector == sic_pkg::VEC_NMI && o_irq_priority == sic_pkg::PRI_NMI)
    else $error("masked request served");
  chk_wdt_mode: assert property (o_irq_req && !$past(i_wdt_interval_mode)
    |-> o_irq_vector != sic_pkg::VEC_WDT) else $error("wdt in reset mode");
  chk_comp_served: assert property (!o_power_up_clear &&
    $past(i_gie && i_comparator_flag && !o_power_up_clear) |->
    o_irq_req && o_irq_priority >= sic_pkg::PRI_COMP)
    else $error("comparator not served");
  chk_fetch_reset: assert property (i_fetch_valid &&
    i_fetch_addr <= sic_pkg::PERIPH_TOP |-> ##[1:3] o_power_up_clear)
    else $error("bad fetch no reset");
  chk_blank_vector: assert property ($fell(o_power_up_clear) |-> o_mode ==
    ($past(i_reset_vector) == sic_pkg::BLANK_WORD ? 3'h5 : 3'h0))
    else $error("start mode wrong");
  chk_key_decode: assert property ($past(i_arst_n) |->
    o_loader_disabled == ($past(i_loader_key) == sic_pkg::KEY_LOADER_OFF) &&
    o_erase_guard == ($past(i_loader_key) == sic_pkg::KEY_ERASE_GUARD))
    else $error("key decode");

  cov_wake: cover property (o_mode == 3'h4 ##1 o_mode == 3'h0);
  cov_nmi: cover property (o_irq_req && !i_gie);
  cov_blank: cover property ($fell(o_power_up_clear) && o_mode == 3'h5);
endmodule : sic_checker

`default_nettype wire

/* verification/sic_periph_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sic_periph_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // bench requests
  input wire logic [5:0] i_set,
  input wire logic i_clr,
  // pending flags toward the controller
  output logic [5:0] o_flags
);
  logic [5:0] flags_ff;
  // flags live here, not in the controller; software clears them here
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flags_ff <= 6'h00;
    end else begin
      flags_ff <= i_clr ? 6'h00 : (flags_ff | i_set);
    end
  end
  assign o_flags = flags_ff;
endmodule : sic_periph_model

`default_nettype wire

/* verification/sic_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none

bind sic_ctrl sic_checker u_sic_checker (.*);

module sic_ctrl_bench;
  logic clk, arst_n, wr, rd, gie, swr, reti, fv, wim, wexp, tunable_oscillator, clr;
  logic pin_n, nmi_mode, flash_key_violation_flag, oscf, irq, power_up_clear, halt, aux, mclk, pclk;
  logic dcg, xtal, ldis, eg, seen;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] lvl, mode;
  logic [15:0] faddr, rvec, key, vec;
  logic [5:0] pset, flags;
  logic [4:0] pri;
  int errors, num_checks, cycles, ie_m, ifg_m, fl_m, r;

  sic_ctrl u_sic_ctrl (
    .i_core_clk(clk), .i_arst_n(arst_n), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_rst_pin_n(pin_n), .i_pin_nmi_mode(nmi_mode), .i_gie(gie),
    .i_sleep_wr(swr), .i_sleep_level(lvl), .i_reti(reti), .i_fetch_valid(fv),
    .i_fetch_addr(faddr), .i_reset_vector(rvec), .i_loader_key(key),
    .i_wdt_expire(wexp), .i_wdt_interval_mode(wim), .i_key_violation(flash_key_violation_flag),
    .i_osc_fault(oscf), .i_access_violation_flag(flags[5]),
    .i_comparator_flag(flags[4]), .i_timer_zero_flag(flags[3]),
    .i_timer_other_flag(flags[2]), .i_port_two_flag(flags[1]),
    .i_port_one_flag(flags[0]), .i_dco_used_active(tunable_oscillator), .o_irq_req(irq),
    .o_irq_vector(vec), .o_irq_priority(pri), .o_power_up_clear(power_up_clear),
    .o_mode(mode), .o_cpu_halt(halt), .o_aux_clk_en(aux),
    .o_main_clk_en(mclk), .o_periph_clk_en(pclk), .o_dc_gen_en(dcg),
    .o_xtal_en(xtal), .o_loader_disabled(ldis), .o_erase_guard(eg)
  );
  sic_periph_model u_sic_periph_model (.i_clk(clk), .i_arst_n(arst_n),
    .i_set(pset), .i_clr(clr), .o_flags(flags));

  task automatic stop_test();
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [20:0] s, input logic [20:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic look();
    cyc(2);
    @(negedge clk);
  endtask : look

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr8

  task automatic rdc(input logic [7:0] a, input int e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e[7:0]);
  endtask : rdc

  task automatic mreq(input logic ret, input logic [2:0] l);
    @(posedge clk);
    swr <= !ret;
    reti <= ret;
    lvl <= l;
    @(posedge clk);
    swr <= 1'b0;
    reti <= 1'b0;
  endtask : mreq

  task automatic clear_all();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wr8(sic_pkg::ADDR_IFG1, 8'h06);
    fl_m = 0;
    ifg_m = 6;
  endtask : clear_all

  task automatic do_reset();
    @(posedge clk);
    arst_n <= 1'b0;
    cyc(4);
    arst_n <= 1'b1;
    cyc(2);
    ie_m = 0;
    ifg_m = 6;
    fl_m = 0;
  endtask : do_reset

  function automatic logic [5:0] gates(input int m, input logic d);
    case (m)
      0: return 6'h1F;
      1: return 6'h37;
      2: return {4'hD, d, 1'b1};
      3: return 6'h33;
      4: return 6'h31;
      default: return 6'h20;
    endcase
  endfunction : gates

  // pin group ignores gie; maskable order follows fixed priorities
  function automatic logic [20:0] exp_irq();
    if (((ie_m & ifg_m & 18) | (ie_m & fl_m & 32)) != 0)
      return {sic_pkg::PRI_NMI, sic_pkg::VEC_NMI};
    if (!gie) return 21'h0;
    if (fl_m[4]) return {sic_pkg::PRI_COMP, sic_pkg::VEC_COMP};
    if ((ie_m & ifg_m & 1) != 0 && wim)
      return {sic_pkg::PRI_WDT, sic_pkg::VEC_WDT};
    if (fl_m[3]) return {sic_pkg::PRI_TMR_ZERO, sic_pkg::VEC_TMR_ZERO};
    if (fl_m[2]) return {sic_pkg::PRI_TMR_OTHER, sic_pkg::VEC_TMR_OTHER};
    if (fl_m[1]) return {sic_pkg::PRI_PORT_TWO, sic_pkg::VEC_PORT_TWO};
    if (fl_m[0]) return {sic_pkg::PRI_PORT_ONE, sic_pkg::VEC_PORT_ONE};
    return 21'h0;
  endfunction : exp_irq

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    {arst_n, wr, rd, gie, swr, reti, fv, wim, wexp, tunable_oscillator, clr} = '0;
    {pin_n, nmi_mode, flash_key_violation_flag, oscf} = 4'h8;
    {addr, wdata, lvl, faddr, pset} = '0;
    rvec = 16'hE000;
    key = 16'h1234;
    void'($urandom(39173));
    do_reset();
    rdc(sic_pkg::ADDR_IE1, 0);
    rdc(sic_pkg::ADDR_IFG1, 6);
    wr8(8'h01, 8'hFF);
    for (int a = 1; a < 5; a += 2) rdc(a[7:0], 0);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      key <= (k == 0) ? 16'hAA55 : (k == 1) ? 16'h0000 : 16'($urandom);
      look();
      chk({ldis, eg}, {key == 16'hAA55, key == 16'h0000});
    end
    for (int m = 0; m < 13; m++) begin
      @(posedge clk);
      tunable_oscillator <= m >= 6;
      mreq(1'b0, (m == 12) ? 3'h7 : 3'(m % 6));
      look();
      chk(mode, (m == 12) ? 5 : m % 6);
      chk({halt, aux, mclk, pclk, dcg, xtal},
          gates((m == 12) ? 5 : m % 6, tunable_oscillator));
    end
    @(posedge clk);
    gie <= 1'b1;
    mreq(1'b0, 3'h4);
    pset <= 6'h10;
    fl_m = 16;
    look();
    pset <= 6'h00;
    chk(mode, 0);
    clear_all();
    mreq(1'b1, 3'h0);
    look();
    chk(mode, 4);
    mreq(1'b0, 3'h0);
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      wr8(sic_pkg::ADDR_IE1, r[7:0]);
      ie_m = r & 51;
      @(posedge clk);
      pset <= r[13:8];
      gie <= r[14];
      wim <= r[15];
      wexp <= r[16];
      fl_m = r[13:8];
      if (r[16] && !r[15]) ie_m = 0;
      ifg_m = ifg_m | r[16];
      @(posedge clk);
      pset <= 6'h00;
      wexp <= 1'b0;
      look();
      chk({pri, vec}, exp_irq());
      chk(irq, exp_irq() != 0);
      rdc(sic_pkg::ADDR_IFG1, ifg_m);
      rdc(sic_pkg::ADDR_IE1, ie_m);
      clear_all();
    end
    wr8(sic_pkg::ADDR_IE1, 8'h33);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      fv <= 1'b1;
      faddr <= k ? 16'h01FE : sic_pkg::CODE_BASE;
      @(posedge clk);
      fv <= 1'b0;
      seen = 1'b0;
      repeat (4) begin
        @(negedge clk);
        seen = seen | power_up_clear;
      end
      chk(seen, k);
    end
    cyc(4);
    rdc(sic_pkg::ADDR_IE1, 0);
    @(posedge clk);
    gie <= 1'b0;
    nmi_mode <= 1'b1;
    pin_n <= 1'b0;
    oscf <= 1'b1;
    flash_key_violation_flag <= 1'b1;
    @(posedge clk);
    oscf <= 1'b0;
    flash_key_violation_flag <= 1'b0;
    cyc(6);
    rdc(sic_pkg::ADDR_IFG1, 8'h17);
    wr8(sic_pkg::ADDR_IE1, 8'h10);
    look();
    chk({pri, vec}, {sic_pkg::PRI_NMI, sic_pkg::VEC_NMI});
    @(posedge clk);
    pin_n <= 1'b1;
    cyc(4);
    nmi_mode <= 1'b0;
    pin_n <= 1'b0;
    cyc(8);
    @(negedge clk);
    chk(power_up_clear, 1);
    @(posedge clk);
    pin_n <= 1'b1;
    cyc(8);
    rdc(sic_pkg::ADDR_IFG1, 8'h0E);
    @(posedge clk);
    rvec <= 16'hFFFF;
    do_reset();
    look();
    chk(mode, 5);
    chk({halt, aux, mclk, pclk, dcg, xtal}, 6'h20);
    stop_test();
  end
endmodule : sic_ctrl_bench

`default_nettype wire
